// *** bench/tfc_cutoff_assertions.sv ***
// Port checker for the forced-cutoff unit, bound into the unit
`timescale 1ns/1ps

module tfc_cutoff_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [tfc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pins
  input wire tfc_pkg::tfc_pins_t pins_o
);
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic acc;
  logic mapped;
  assign acc = psel_i && penable_i;
  assign mapped = paddr_i[1:0] == 2'h0 && paddr_i[11:10] == 2'h0
    && paddr_i[9:2] >= tfc_pkg::IDX_CTRL && paddr_i[9:2] <= tfc_pkg::IDX_MODE;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ready_one_wait_a: assert property (acc && !pready_o |=> pready_o)
    else $error("pready late after access phase");
  ready_one_cycle_a: assert property (pready_o |=> !pready_o)
    else $error("pready held past one cycle");
  ready_in_access_a: assert property (pready_o |-> acc && $past(acc))
    else $error("pready outside second access cycle");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data not zero while idle");
  unmapped_err_a: assert property (pready_o && !mapped |-> pslverr_o)
    else $error("unmapped access not flagged");
  mapped_ok_a: assert property (pready_o && mapped |-> !pslverr_o)
    else $error("mapped access flagged as error");
  reset_pins_a: assert property ($fell(rst_i) |-> pins_o == 16'h0000)
    else $error("pins not idle after reset");
endmodule // tfc_cutoff_checker

bind tfc_output_cutoff_unit tfc_cutoff_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .pins_o(pins_o));

// *** bench/tfc_timer_model.sv ***
// Behavioural two-channel timer that feeds the cutoff unit
`timescale 1ns/1ps

module tfc_timer_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Channel run enables
  input wire logic run0_i,
  input wire logic run1_i,
  // Timer outputs
  output tfc_pkg::tfc_pins_t pins_o,
  output logic zero0_o,
  output logic zero1_o,
  output logic ref_o
);
  logic [2:0] cnt0_q;
  logic [2:0] cnt1_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt0_q <= 3'h1;
      cnt1_q <= 3'h1;
    end else begin
      if (run0_i) cnt0_q <= cnt0_q + 3'h1;
      if (run1_i) cnt1_q <= cnt1_q + 3'h1;
    end
  end
  // A stopped counter sitting at zero must not free anything
  assign zero0_o = run0_i && cnt0_q == 3'h0;
  assign zero1_o = run1_i && cnt1_q == 3'h0;
  // Reference edges kept away from the zero count
  assign ref_o = cnt0_q >= 3'h3 && cnt0_q < 3'h6;
  assign pins_o = {1'b0, cnt1_q, 1'b1, cnt0_q, 8'hFF};
endmodule // tfc_timer_model

// *** bench/timer_output_forced_cutoff_test.sv ***
// Self-checking bench for the forced-cutoff unit
`timescale 1ns/1ps

module timer_output_forced_cutoff_test;
  typedef struct {
    logic [7:0] idx;
    logic [31:0] wd;
    logic [31:0] rd;
    logic er;
  } tfc_row_t;
  logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic cmp, ext, evt, z0, z1, refp, run0, run1, e;
  tfc_pkg::tfc_pins_t tpins, pins_o;
  tfc_row_t rows [8];
  int fails, n_checks;

  tfc_output_cutoff_unit uut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .comparator0_i(cmp), .external_interrupt_input_i(ext),
    .event_link_controller_i(evt), .timer_pins_i(tpins),
    .channel0_counter_zero_i(z0), .channel1_counter_zero_i(z1),
    .complementary_reference_pin_i(refp), .pins_o(pins_o));
  tfc_timer_model tmr (.clk_i(clk_i), .rst_i(rst_i), .run0_i(run0),
    .run1_i(run1), .pins_o(tpins), .zero0_o(z0), .zero1_o(z1), .ref_o(refp));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {2'h0, idx, 2'h0};
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    // Values read here are those that stood up to this rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] x);
    bus(1'b0, idx, 32'h0000_0000);
    chk(r, x);
  endtask
  // Group flags only: the event source never sets the detect flag, it stays low
  task automatic st(input logic [31:0] x);
    bus(1'b0, tfc_pkg::IDX_STAT, 32'h0000_0000);
    chk(r & 32'h0000_0006, x);
  endtask
  task automatic wait_on(input logic [1:0] k);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (!(k == 2'h0 ? z0 : k == 2'h1 ? z1 : refp == k[0]) && n < 200);
    if (n == 200) begin
      fails++;
      close_out();
    end
  endtask
  task automatic run(input logic [1:0] k);
    if (k == 2'h1) run1 <= 1'b1;
    else run0 <= 1'b1;
    wait_on(k);
    cyc(3);
    run0 <= 1'b0;
    run1 <= 1'b0;
  endtask
  task automatic pin_chk(input logic [15:0] lv);
    tfc_pkg::tfc_pins_t x;
    logic [7:0] m;
    x = tpins;
    m = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      case (lv[2*i +: 2])
        2'b01: begin x.oe[i] = 1'b0; m[i] = 1'b0; end
        2'b10: begin x.oe[i] = 1'b1; x.level[i] = 1'b0; end
        2'b11: begin x.oe[i] = 1'b1; x.level[i] = 1'b1; end
        default: ;
      endcase
    end
    chk({16'h0000, pins_o.oe, pins_o.level & m},
        {16'h0000, x.oe, x.level & m});
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, psel_i, penable_i, pwrite_i} = 4'h8;
    {cmp, ext, evt, run0, run1} = 5'h00;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    fails = 0;
    n_checks = 0;
    rows = '{'{8'h59, 32'hFFFF_FF1B, 32'h0000_001B, 1'b0},
             '{8'h5A, 32'h0000_00E4, 32'h0000_00E4, 1'b0},
             '{8'h5B, 32'h0000_0003, 32'h0000_0003, 1'b0},
             '{8'h5D, 32'h0000_0002, 32'h0000_0002, 1'b0},
             '{8'h58, 32'h0000_0020, 32'h0000_0020, 1'b0},
             '{8'h58, 32'h0000_0002, 32'h0000_0000, 1'b0},
             '{8'h5C, 32'h0000_00FF, 32'h0000_0000, 1'b0},
             '{8'h5E, 32'h0000_0055, 32'h0000_0000, 1'b1}};
    cyc(2);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      rd(rows[i].idx, rows[i].rd);
      chk({31'h0, e}, {31'h0, rows[i].er});
    end
    $display("done: register table");
    cyc(1);
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    cyc(1);
    chk({16'h0000, pins_o}, 32'h0000_0000);
    for (int i = 8'h58; i <= 8'h5D; i++) rd(8'(i), 32'h0000_0000);
    $display("done: reset");
    bus(1'b1, tfc_pkg::IDX_LVL0, 32'h0000_00E4);
    bus(1'b1, tfc_pkg::IDX_LVL1, 32'h0000_00C0);
    cmp <= 1'b1;
    bus(1'b1, tfc_pkg::IDX_CTRL, 32'h0000_0008);
    cyc(6);
    rd(tfc_pkg::IDX_STAT, 32'h0000_0001);
    cmp <= 1'b0;
    cyc(6);
    rd(tfc_pkg::IDX_STAT, 32'h0000_0000);
    cmp <= 1'b1;
    cyc(6);
    rd(tfc_pkg::IDX_STAT, 32'h0000_0007);
    pin_chk(16'hC0E4);
    cmp <= 1'b0;
    run(2'h0);
    rd(tfc_pkg::IDX_STAT, 32'h0000_0004);
    pin_chk(16'hC000);
    run(2'h1);
    rd(tfc_pkg::IDX_STAT, 32'h0000_0000);
    pin_chk(16'h0000);
    $display("done: hardware release");
    ext <= 1'b1;
    bus(1'b1, tfc_pkg::IDX_MODE, 32'h0000_0001);
    bus(1'b1, tfc_pkg::IDX_CTRL, 32'h0000_0030);
    cyc(4);
    ext <= 1'b0;
    cyc(6);
    rd(tfc_pkg::IDX_STAT, 32'h0000_0007);
    ext <= 1'b1;
    run(2'h0);
    rd(tfc_pkg::IDX_STAT, 32'h0000_0000);
    $display("done: reset-synchronous release");
    bus(1'b1, tfc_pkg::IDX_MODE, 32'h0000_0000);
    bus(1'b1, tfc_pkg::IDX_CTRL, 32'h0000_0039);
    evt <= 1'b1;
    cyc(1);
    evt <= 1'b0;
    st(32'h0000_0006);
    bus(1'b1, tfc_pkg::IDX_CTRL, 32'h0000_003B);
    st(32'h0000_0000);
    rd(tfc_pkg::IDX_CTRL, 32'h0000_0039);
    bus(1'b1, tfc_pkg::IDX_CTRL, 32'h0000_003D);
    evt <= 1'b1;
    cyc(1);
    evt <= 1'b0;
    bus(1'b1, tfc_pkg::IDX_CTRL, 32'h0000_003F);
    rd(tfc_pkg::IDX_CTRL, 32'h0000_003F);
    run(2'h0);
    st(32'h0000_0004);
    run(2'h1);
    st(32'h0000_0000);
    rd(tfc_pkg::IDX_CTRL, 32'h0000_003D);
    $display("done: software release");
    bus(1'b1, tfc_pkg::IDX_MODE, 32'h0000_0002);
    bus(1'b1, tfc_pkg::IDX_EDGE, 32'h0000_0001);
    bus(1'b1, tfc_pkg::IDX_CTRL, 32'h0000_0008);
    // Park the counter with the reference low before the trip
    run0 <= 1'b1;
    wait_on(2'h0);
    cyc(1);
    run0 <= 1'b0;
    cmp <= 1'b1;
    cyc(6);
    cmp <= 1'b0;
    run0 <= 1'b1;
    wait_on(2'h3);
    cyc(1);
    run0 <= 1'b0;
    st(32'h0000_0006);
    run0 <= 1'b1;
    wait_on(2'h2);
    cyc(5);
    run0 <= 1'b0;
    st(32'h0000_0000);
    $display("done: complementary release");
    close_out();
  end
endmodule // timer_output_forced_cutoff_test

// *** rtl/tfc_output_cutoff_unit.sv ***
// Output forced-cutoff unit between a two-channel timer and its pins
`timescale 1ns/1ps

module tfc_output_cutoff_unit #(
  parameter int unsigned PINS_PER_GROUP = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [tfc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Trip sources
  input wire logic comparator0_i,
  input wire logic external_interrupt_input_i,
  input wire logic event_link_controller_i,
  // Timer side
  input wire tfc_pkg::tfc_pins_t timer_pins_i,
  input wire logic channel0_counter_zero_i,
  input wire logic channel1_counter_zero_i,
  input wire logic complementary_reference_pin_i,
  // Pin side
  output tfc_pkg::tfc_pins_t pins_o
);

  localparam int unsigned NPINS = 2 * PINS_PER_GROUP;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic idx_hit(
    input logic [tfc_pkg::ADDR_W-1:0] addr,
    input logic [7:0] idx
  );
    idx_hit = (addr == {2'b00, idx, 2'b00});
  endfunction

  function automatic logic group_enabled(input logic [7:0] lvl);
    group_enabled = (lvl != 8'h00);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tfc_pkg::tfc_ctrl_t ctrl_q;
  logic [7:0] lvl0_q;
  logic [7:0] lvl1_q;
  tfc_pkg::tfc_edge_t edge_q;
  tfc_pkg::tfc_tmode_t mode_q;
  logic release_request_q;
  logic group0_cutoff_flag_q;
  logic group1_cutoff_flag_q;
  logic source_detect_flag_q;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic cmp_meta_q;
  logic cmp_sync_q;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ref_meta_q;
  logic ref_sync_q;
  logic ref_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      cmp_meta_q <= comparator0_i;
      cmp_sync_q <= cmp_meta_q;
      ext_meta_q <= external_interrupt_input_i;
      ext_sync_q <= ext_meta_q;
      ref_meta_q <= complementary_reference_pin_i;
      ref_sync_q <= ref_meta_q;
      ref_prev_q <= ref_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: the answer comes one cycle into the access phase
  logic access;
  logic wr_fire;
  logic map_hit;
  logic [7:0] rd_byte;

  assign access = psel_i && penable_i;
  assign wr_fire = access && pready_o && pwrite_i;

  always_comb begin
    map_hit = 1'b1;
    rd_byte = 8'h00;
    if (idx_hit(paddr_i, tfc_pkg::IDX_CTRL)) begin
      rd_byte = {ctrl_q.rsvd, ctrl_q.source_polarity, ctrl_q.source_select,
                 ctrl_q.timed_release_select, release_request_q,
                 ctrl_q.release_mode_select};
    end else if (idx_hit(paddr_i, tfc_pkg::IDX_LVL0)) begin
      rd_byte = lvl0_q;
    end else if (idx_hit(paddr_i, tfc_pkg::IDX_LVL1)) begin
      rd_byte = lvl1_q;
    end else if (idx_hit(paddr_i, tfc_pkg::IDX_EDGE)) begin
      rd_byte = {6'h00, edge_q};
    end else if (idx_hit(paddr_i, tfc_pkg::IDX_STAT)) begin
      rd_byte = {5'h00, group1_cutoff_flag_q, group0_cutoff_flag_q,
                 source_detect_flag_q};
    end else if (idx_hit(paddr_i, tfc_pkg::IDX_MODE)) begin
      rd_byte = {6'h00, mode_q};
    end else begin
      map_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= tfc_pkg::RDATA_RST;
    end else begin
      pready_o <= access && !pready_o;
      pslverr_o <= access && !pready_o && !map_hit;
      if (access && !pready_o && !pwrite_i) begin
        prdata_o <= {24'h00_0000, rd_byte};
      end else begin
        prdata_o <= tfc_pkg::RDATA_RST;
      end
    end
  end

  // Configuration registers; cutoff levels are meant to be left alone
  // while a cutoff is held, but nothing blocks such a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= tfc_pkg::tfc_ctrl_t'(tfc_pkg::CTRL_RST);
      lvl0_q <= tfc_pkg::LVL_RST;
      lvl1_q <= tfc_pkg::LVL_RST;
      edge_q <= tfc_pkg::tfc_edge_t'(tfc_pkg::EDGE_RST);
      mode_q <= tfc_pkg::tfc_tmode_t'(tfc_pkg::MODE_RST);
    end else if (wr_fire) begin
      if (idx_hit(paddr_i, tfc_pkg::IDX_CTRL)) begin
        ctrl_q <= tfc_pkg::tfc_ctrl_t'(pwdata_i[7:0]);
      end
      if (idx_hit(paddr_i, tfc_pkg::IDX_LVL0)) begin
        lvl0_q <= pwdata_i[7:0];
      end
      if (idx_hit(paddr_i, tfc_pkg::IDX_LVL1)) begin
        lvl1_q <= pwdata_i[7:0];
      end
      if (idx_hit(paddr_i, tfc_pkg::IDX_EDGE)) begin
        edge_q <= tfc_pkg::tfc_edge_t'(pwdata_i[1:0]);
      end
      if (idx_hit(paddr_i, tfc_pkg::IDX_MODE)) begin
        mode_q <= tfc_pkg::tfc_tmode_t'(pwdata_i[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Trip detection
  // ----------------------------------------------------------------
  logic src_level;
  logic detect_now;
  logic detect_prev_q;
  tfc_pkg::tfc_src_t src_prev_q;
  logic trip;

  always_comb begin
    unique case (ctrl_q.source_select)
      tfc_pkg::SRC_CMP: src_level = cmp_sync_q;
      tfc_pkg::SRC_EXT: src_level = ext_sync_q;
      tfc_pkg::SRC_EVT: src_level = 1'b0;
      tfc_pkg::SRC_NONE: src_level = 1'b0;
    endcase
  end

  // Polarity only means something for the two level sources
  assign detect_now = (ctrl_q.source_select == tfc_pkg::SRC_CMP ||
                       ctrl_q.source_select == tfc_pkg::SRC_EXT) &&
                      (src_level ^ ctrl_q.source_polarity);

  // A level already detected at the moment of selection trips nothing
  assign trip = (detect_now && !detect_prev_q &&
                 ctrl_q.source_select == src_prev_q) ||
                (ctrl_q.source_select == tfc_pkg::SRC_EVT &&
                 event_link_controller_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      detect_prev_q <= 1'b0;
      src_prev_q <= tfc_pkg::SRC_NONE;
      source_detect_flag_q <= 1'b0;
    end else begin
      detect_prev_q <= detect_now;
      src_prev_q <= ctrl_q.source_select;
      source_detect_flag_q <= detect_now;
    end
  end

  // ----------------------------------------------------------------
  // Release timing
  // ----------------------------------------------------------------
  logic ref_edge;
  logic rel_evt0;
  logic rel_evt1;
  logic hw_ok;
  logic timed_ok;
  logic sw_now;
  logic clr0;
  logic clr1;
  logic any_cut;

  always_comb begin
    unique case (edge_q)
      tfc_pkg::EDGE_RISE: ref_edge = ref_sync_q && !ref_prev_q;
      tfc_pkg::EDGE_FALL: ref_edge = !ref_sync_q && ref_prev_q;
      tfc_pkg::EDGE_BOTH: ref_edge = ref_sync_q ^ ref_prev_q;
      tfc_pkg::EDGE_NONE: ref_edge = 1'b0;
    endcase
  end

  always_comb begin
    unique case (mode_q)
      tfc_pkg::TMODE_STD: begin
        rel_evt0 = channel0_counter_zero_i;
        rel_evt1 = channel1_counter_zero_i;
      end
      tfc_pkg::TMODE_RSYNC: begin
        rel_evt0 = channel0_counter_zero_i;
        rel_evt1 = channel0_counter_zero_i;
      end
      tfc_pkg::TMODE_COMPL: begin
        rel_evt0 = ref_edge;
        rel_evt1 = ref_edge;
      end
      tfc_pkg::TMODE_RSVD: begin
        rel_evt0 = 1'b0;
        rel_evt1 = 1'b0;
      end
    endcase
  end

  // Hardware release waits for the source to be back inside limits
  assign hw_ok = !ctrl_q.release_mode_select && !detect_now;
  assign timed_ok = hw_ok || (ctrl_q.release_mode_select &&
                              ctrl_q.timed_release_select &&
                              release_request_q);
  assign sw_now = ctrl_q.release_mode_select &&
                  !ctrl_q.timed_release_select &&
                  release_request_q;
  assign clr0 = sw_now || (timed_ok && rel_evt0);
  assign clr1 = sw_now || (timed_ok && rel_evt1);
  assign any_cut = group0_cutoff_flag_q || group1_cutoff_flag_q;

  // ----------------------------------------------------------------
  // Cutoff state and release request
  // ----------------------------------------------------------------
  // A trip in the same cycle as a release keeps the group cut off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      group0_cutoff_flag_q <= 1'b0;
      group1_cutoff_flag_q <= 1'b0;
    end else begin
      if (trip && group_enabled(lvl0_q)) begin
        group0_cutoff_flag_q <= 1'b1;
      end else if (clr0) begin
        group0_cutoff_flag_q <= 1'b0;
      end
      if (trip && group_enabled(lvl1_q)) begin
        group1_cutoff_flag_q <= 1'b1;
      end else if (clr1) begin
        group1_cutoff_flag_q <= 1'b0;
      end
    end
  end

  // Request can only be raised while a cutoff is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      release_request_q <= 1'b0;
    end else if (wr_fire && idx_hit(paddr_i, tfc_pkg::IDX_CTRL) &&
                 pwdata_i[1] && any_cut) begin
      release_request_q <= 1'b1;
    end else if (!any_cut) begin
      release_request_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin override
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    logic cut_active;
    tfc_pkg::tfc_cut_t setting;

    assign setting = (p < PINS_PER_GROUP) ?
                     tfc_pkg::tfc_cut_t'(lvl0_q[2*(p%PINS_PER_GROUP) +: 2]) :
                     tfc_pkg::tfc_cut_t'(lvl1_q[2*(p%PINS_PER_GROUP) +: 2]);
    assign cut_active = (p < PINS_PER_GROUP) ? group0_cutoff_flag_q :
                                               group1_cutoff_flag_q;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pins_o.level[p] <= 1'b0;
        pins_o.oe[p] <= 1'b0;
      end else if (cut_active && setting != tfc_pkg::CUT_OFF) begin
        pins_o.level[p] <= (setting == tfc_pkg::CUT_HIGH);
        pins_o.oe[p] <= (setting != tfc_pkg::CUT_HIZ);
      end else begin
        pins_o.level[p] <= timer_pins_i.level[p];
        pins_o.oe[p] <= timer_pins_i.oe[p];
      end
    end
  end

endmodule // tfc_output_cutoff_unit

// *** rtl/tfc_pkg.sv ***
// Package for the timer output forced-cutoff unit: map, layouts, types
package tfc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] IDX_CTRL = 8'h58;
  localparam logic [7:0] IDX_LVL0 = 8'h59;
  localparam logic [7:0] IDX_LVL1 = 8'h5A;
  localparam logic [7:0] IDX_EDGE = 8'h5B;
  localparam logic [7:0] IDX_STAT = 8'h5C;
  localparam logic [7:0] IDX_MODE = 8'h5D;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LVL_RST = 8'h00;
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_CMP  = 2'b01,
    SRC_EXT  = 2'b10,
    SRC_EVT  = 2'b11
  } tfc_src_t;

  typedef enum logic [1:0] {
    CUT_OFF  = 2'b00,
    CUT_HIZ  = 2'b01,
    CUT_LOW  = 2'b10,
    CUT_HIGH = 2'b11
  } tfc_cut_t;

  typedef enum logic [1:0] {
    TMODE_STD   = 2'b00,
    TMODE_RSYNC = 2'b01,
    TMODE_COMPL = 2'b10,
    TMODE_RSVD  = 2'b11
  } tfc_tmode_t;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_NONE = 2'b11
  } tfc_edge_t;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsvd;
    logic source_polarity;
    tfc_src_t source_select;
    logic timed_release_select;
    logic release_request;
    logic release_mode_select;
  } tfc_ctrl_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic group1_cutoff_flag;
    logic group0_cutoff_flag;
    logic source_detect_flag;
  } tfc_stat_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } tfc_pins_t;

endpackage
